// >>> verilog/pfcn_pkg.sv
package pfcn_pkg;

  localparam int          PFCN_DW    = 32;
  localparam int          PFCN_HALF  = 16;
  localparam int          PFCN_BYTES = 4;
  localparam int          PFCN_PINS  = 16;

  // Byte addresses of the registers; bits 3:2 pick the alias.
  localparam logic [15:0] OFF_DIR  = 16'h6510;
  localparam logic [15:0] OFF_LVL  = 16'h6520;
  localparam logic [15:0] OFF_LAT  = 16'h6530;
  localparam logic [15:0] OFF_ODC  = 16'h6540;
  localparam logic [15:0] OFF_PU   = 16'h6550;
  localparam logic [15:0] OFF_PD   = 16'h6560;
  localparam logic [15:0] OFF_CTRL = 16'h6570;
  localparam logic [15:0] OFF_CNEN = 16'h6580;
  localparam logic [15:0] OFF_STAT = 16'h6590;
  localparam logic [15:0] OFF_IST  = 16'h65A0;
  localparam logic [15:0] OFF_IMSK = 16'h65B0;

  localparam logic [1:0]  ALIAS_BASE = 2'h0;
  localparam logic [1:0]  ALIAS_CLR  = 2'h1;
  localparam logic [1:0]  ALIAS_SET  = 2'h2;
  localparam logic [1:0]  ALIAS_INV  = 2'h3;

  localparam logic [31:0] PIN_IMPL  = 32'h0000_31FF;
  localparam logic [31:0] CN_IMPL   = 32'h0000_31BF;
  localparam logic [31:0] CTRL_IMPL = 32'h0000_A000;
  localparam int          CTRL_ON   = 15;
  localparam int          CTRL_STOP_IN_IDLE = 13;

  localparam logic [31:0] DIR_RST   = 32'h0000_31FF;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ZERO_W    = 32'h0000_0000;
  localparam logic [3:0]  STRB_ALL  = 4'hF;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] dir;
    logic [31:0] lat;
    logic [31:0] odc;
    logic [31:0] pu;
    logic [31:0] pd;
    logic [31:0] ctrl;
    logic [31:0] cn_en;
    logic [31:0] cn_flag;
    logic [31:0] pin_lvl;
    logic [31:0] irq_st;
    logic [31:0] irq_mask;
  } pfcn_regs_s;

  function automatic logic [31:0] pfcn_strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = ZERO_W;
    for (int i = 0; i < PFCN_BYTES; i++) begin
      m[8*i +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] pfcn_alias(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [31:0] m,
                                             input logic [1:0]  sel);
    case (sel)
      ALIAS_CLR: return old & ~(data & m);
      ALIAS_SET: return old | (data & m);
      ALIAS_INV: return old ^ (data & m);
      default:   return (old & ~m) | (data & m);
    endcase
  endfunction

  function automatic logic pfcn_hit(input logic [15:0] addr, input logic [15:0] off);
    return addr[15:4] == off[15:4];
  endfunction

endpackage

// >>> verilog/pfcn_axil_slave.sv
`timescale 1ns/1ps
module pfcn_axil_slave #(
  parameter int ADDR_W = 16
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pfcn_pkg::PFCN_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [pfcn_pkg::PFCN_DW-1:0]      s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic                              wr_en,
  output logic [15:0]                       wr_addr,
  output logic [pfcn_pkg::PFCN_DW-1:0]      wr_data,
  output logic [3:0]                        wr_strb,
  input  wire logic                         wr_err,
  output logic                              rd_en,
  output logic [15:0]                       rd_addr,
  input  wire logic [pfcn_pkg::PFCN_DW-1:0] rd_data,
  input  wire logic                         rd_err
);
  import pfcn_pkg::*;

  if (ADDR_W < 16) begin : g_chk
    $error("ADDR_W must be at least 16.");
  end

  typedef struct packed {
    logic [15:0] aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pfcn_axil_s;

  pfcn_axil_s st_r;
  pfcn_axil_s st_nxt;

  assign s_axi_awready = ~st_r.aw_have & ~st_r.bvalid;
  assign s_axi_wready  = ~st_r.w_have & ~st_r.bvalid;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign wr_en         = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
  assign wr_addr       = st_r.aw_addr;
  assign wr_data       = st_r.w_data;
  assign wr_strb       = st_r.w_strb;
  assign rd_en         = s_axi_arvalid & ~st_r.rvalid;
  assign rd_addr       = s_axi_araddr[15:0];

  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_addr = s_axi_awaddr[15:0];
      st_nxt.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.w_have = 1'b1;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_en) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_en) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_data;
      st_nxt.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // pfcn_axil_slave

// >>> verilog/pfcn_change_det.sv
`timescale 1ns/1ps
module pfcn_change_det (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [pfcn_pkg::PFCN_PINS-1:0] pins,
  input  wire logic [pfcn_pkg::PFCN_PINS-1:0] enable,
  input  wire logic                           active,
  output logic [pfcn_pkg::PFCN_PINS-1:0]      change
);
  import pfcn_pkg::*;

  typedef struct packed {
    logic [PFCN_PINS-1:0] prev;
    logic                 primed;
  } pfcn_det_s;

  pfcn_det_s st_r;
  pfcn_det_s st_nxt;

  // The previous sample follows the pins even while detection is off, so that
  // switching the module on does not report stale differences.
  for (genvar i = 0; i < PFCN_PINS; i++) begin : g_pin
    assign change[i] = active & st_r.primed & enable[i] & (pins[i] ^ st_r.prev[i]);
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.prev   = pins;
    st_nxt.primed = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // pfcn_change_det

// >>> verilog/pfcn_port.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// - Each register except the change flags and the interrupt status and mask has clear, set and invert aliases at plus 0x4, 0x8 and 0xC acting on ones.
// - Bits 31:16 of every port register read as zero and reset to zero.
// - Only the change-notice control register has a defined zero reset; others are unspecified.
// - Direction, level, latch, open-drain, pull-up and pull-down hold only bits 0-8, 12, 13.
// - Change enable and change flags hold only pins 0-5, 7, 8, 12, 13; pin 6 reads zero.
module pfcn_port #(
  parameter int ADDR_W = 16
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [pfcn_pkg::PFCN_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [ADDR_W-1:0]              s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [pfcn_pkg::PFCN_DW-1:0]        s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [pfcn_pkg::PFCN_PINS-1:0] pin_level_bits,
  input  wire logic                           idle_mode,
  output logic [pfcn_pkg::PFCN_PINS-1:0]      pad_out,
  output logic [pfcn_pkg::PFCN_PINS-1:0]      pad_oe,
  output logic [pfcn_pkg::PFCN_PINS-1:0]      weak_pullup_enable_bits,
  output logic [pfcn_pkg::PFCN_PINS-1:0]      weak_pulldown_enable_bits,
  output logic                                irq
);
  import pfcn_pkg::*;

  pfcn_regs_s           st_r;
  pfcn_regs_s           st_nxt;
  logic                 wr_en;
  logic [15:0]          wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_err;
  logic                 rd_en;
  logic [15:0]          rd_addr;
  logic [31:0]          rd_data;
  logic                 rd_err;
  logic [31:0]          wm;
  logic [1:0]           walias;
  logic [PFCN_PINS-1:0] cn_event;
  logic                 cn_active;

  pfcn_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Stop-in-idle only matters while the device reports idle.
  assign cn_active = st_r.ctrl[CTRL_ON] & ~(st_r.ctrl[CTRL_STOP_IN_IDLE] & idle_mode);

  pfcn_change_det u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (pin_level_bits),
    .enable  (st_r.cn_en[PFCN_PINS-1:0]),
    .active  (cn_active),
    .change  (cn_event)
  );

  assign wm     = pfcn_strb_mask(wr_strb);
  assign walias = wr_addr[3:2];

  // An open-drain pin only drives its low level; a high latch releases the pad.
  assign pad_out                   = st_r.lat[PFCN_PINS-1:0];
  assign pad_oe                    = ~st_r.dir[PFCN_PINS-1:0]
                                     & ~(st_r.odc[PFCN_PINS-1:0] & st_r.lat[PFCN_PINS-1:0])
                                     & PIN_IMPL[PFCN_PINS-1:0];
  assign weak_pullup_enable_bits   = st_r.pu[PFCN_PINS-1:0];
  assign weak_pulldown_enable_bits = st_r.pd[PFCN_PINS-1:0];
  assign irq                       = |(st_r.irq_st & st_r.irq_mask);

  // Read decode. The interrupt registers have no aliases.
  always_comb begin
    rd_data = ZERO_W;
    rd_err  = 1'b0;
    if (pfcn_hit(rd_addr, OFF_DIR)) begin
      rd_data = st_r.dir;
    end else if (pfcn_hit(rd_addr, OFF_LVL)) begin
      rd_data = st_r.pin_lvl;
    end else if (pfcn_hit(rd_addr, OFF_LAT)) begin
      rd_data = st_r.lat;
    end else if (pfcn_hit(rd_addr, OFF_ODC)) begin
      rd_data = st_r.odc;
    end else if (pfcn_hit(rd_addr, OFF_PU)) begin
      rd_data = st_r.pu;
    end else if (pfcn_hit(rd_addr, OFF_PD)) begin
      rd_data = st_r.pd;
    end else if (pfcn_hit(rd_addr, OFF_CTRL)) begin
      rd_data = st_r.ctrl;
    end else if (pfcn_hit(rd_addr, OFF_CNEN)) begin
      rd_data = st_r.cn_en;
    end else if (pfcn_hit(rd_addr, OFF_STAT)) begin
      rd_data = st_r.cn_flag;
    end else if (pfcn_hit(rd_addr, OFF_IST) && rd_addr[3:2] == ALIAS_BASE) begin
      rd_data = st_r.irq_st;
    end else if (pfcn_hit(rd_addr, OFF_IMSK) && rd_addr[3:2] == ALIAS_BASE) begin
      rd_data = st_r.irq_mask;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    st_nxt         = st_r;
    wr_err         = 1'b0;
    st_nxt.pin_lvl = {{PFCN_HALF{1'b0}}, pin_level_bits} & PIN_IMPL;
    if (wr_en) begin
      if (pfcn_hit(wr_addr, OFF_DIR)) begin
        st_nxt.dir = pfcn_alias(st_r.dir, wr_data, wm, walias) & PIN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_LVL) || pfcn_hit(wr_addr, OFF_LAT)) begin
        // A write to the level register lands in the output latch.
        st_nxt.lat = pfcn_alias(st_r.lat, wr_data, wm, walias) & PIN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_ODC)) begin
        st_nxt.odc = pfcn_alias(st_r.odc, wr_data, wm, walias) & PIN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_PU)) begin
        st_nxt.pu = pfcn_alias(st_r.pu, wr_data, wm, walias) & PIN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_PD)) begin
        st_nxt.pd = pfcn_alias(st_r.pd, wr_data, wm, walias) & PIN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_CTRL)) begin
        st_nxt.ctrl = pfcn_alias(st_r.ctrl, wr_data, wm, walias) & CTRL_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_CNEN)) begin
        st_nxt.cn_en = pfcn_alias(st_r.cn_en, wr_data, wm, walias) & CN_IMPL;
      end else if (pfcn_hit(wr_addr, OFF_STAT)) begin
        st_nxt.cn_flag = st_r.cn_flag;
      end else if (pfcn_hit(wr_addr, OFF_IST) && walias == ALIAS_BASE) begin
        st_nxt.irq_st = st_r.irq_st & ~(wr_data & wm);
      end else if (pfcn_hit(wr_addr, OFF_IMSK) && walias == ALIAS_BASE) begin
        st_nxt.irq_mask = pfcn_alias(st_r.irq_mask, wr_data, wm, ALIAS_BASE) & CN_IMPL;
      end else begin
        wr_err = 1'b1;
      end
    end
    // Reading the pin levels acknowledges the change flags, as in a mismatch
    // scheme; the new event is merged after the clear so that it is never lost.
    if (rd_en && pfcn_hit(rd_addr, OFF_LVL)) begin
      st_nxt.cn_flag = ZERO_W;
    end
    st_nxt.cn_flag = st_nxt.cn_flag | ({{PFCN_HALF{1'b0}}, cn_event} & CN_IMPL);
    st_nxt.irq_st  = st_nxt.irq_st | ({{PFCN_HALF{1'b0}}, cn_event} & CN_IMPL);
  end

  // Registers whose reset is unspecified still get a fixed value here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.dir  <= DIR_RST;
      st_r.ctrl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  set_alias_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_LAT) && walias == ALIAS_SET)
    |=> ((st_r.lat & $past(wr_data) & $past(wm) & PIN_IMPL)
         == ($past(wr_data) & $past(wm) & PIN_IMPL)))
    else $error("Set alias did not set latch bits.");

  inv_alias_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_DIR) && walias == ALIAS_INV)
    |=> (st_r.dir == (($past(st_r.dir) ^ ($past(wr_data) & $past(wm))) & PIN_IMPL)))
    else $error("Invert alias did not toggle direction bits.");

  upper_zero_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_en && !rd_err) |-> (rd_data[PFCN_DW-1:PFCN_HALF] == ZERO_W[PFCN_DW-1:PFCN_HALF]))
    else $error("Upper halfword read not zero.");

  ctrl_reset_a : assert property (
    @(posedge aclk)
    !aresetn |=> (st_r.ctrl == CTRL_RST))
    else $error("Control register not zero after reset.");

  pin_impl_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_en && (pfcn_hit(rd_addr, OFF_DIR) || pfcn_hit(rd_addr, OFF_LVL)))
    |-> ((rd_data & ~PIN_IMPL) == ZERO_W))
    else $error("Unimplemented pin bit read as one.");

  cn_impl_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_CNEN) && walias == ALIAS_BASE
     && wr_strb == STRB_ALL && wr_data == ~ZERO_W)
    |=> (st_r.cn_en == CN_IMPL))
    else $error("Change enable does not match implemented pins.");

  cn_halt_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cn_active |=> ((st_r.cn_flag & ~$past(st_r.cn_flag)) == ZERO_W))
    else $error("Change flag set while detection halted.");

  cn_set_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (cn_active && cn_event != '0)
    |=> ((st_r.cn_flag[PFCN_PINS-1:0] & $past(cn_event)) == $past(cn_event)))
    else $error("Change event did not set its flag.");

  clr_alias_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_ODC) && walias == ALIAS_CLR)
    |=> ((st_r.odc & $past(wr_data) & $past(wm)) == ZERO_W))
    else $error("Clear alias left open-drain bits set.");

  base_write_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_PU) && walias == ALIAS_BASE)
    |=> (st_r.pu == ((($past(st_r.pu) & ~$past(wm)) | ($past(wr_data) & $past(wm)))
                     & PIN_IMPL)))
    else $error("Base write did not load pull-up bits.");

  pin_bits_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((st_r.dir | st_r.lat | st_r.odc | st_r.pu | st_r.pd | st_r.pin_lvl) & ~PIN_IMPL)
    == ZERO_W)
    else $error("Unimplemented pin bit held as one.");

  cn_bits_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((st_r.cn_en | st_r.cn_flag | st_r.irq_st | st_r.irq_mask) & ~CN_IMPL) == ZERO_W)
    else $error("Flag or enable held on a pin without change notice.");

  ctrl_bits_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.ctrl & ~CTRL_IMPL) == ZERO_W)
    else $error("Unimplemented control bit held as one.");

  flag_clear_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_en && pfcn_hit(rd_addr, OFF_LVL))
    |=> ((st_r.cn_flag[PFCN_PINS-1:0] & ~$past(cn_event)) == '0))
    else $error("Level read did not clear change flags.");

  stat_ro_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_STAT) && !rd_en)
    |=> (st_r.cn_flag == ($past(st_r.cn_flag) | {{PFCN_HALF{1'b0}}, $past(cn_event)})))
    else $error("Write changed the change flags.");

  irq_w1c_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && pfcn_hit(wr_addr, OFF_IST) && walias == ALIAS_BASE)
    |=> ((st_r.irq_st & $past(wr_data) & $past(wm)
          & ~{{PFCN_HALF{1'b0}}, $past(cn_event)}) == ZERO_W))
    else $error("Write of one did not clear interrupt status.");

  wr_answer_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en |=> s_axi_bvalid)
    else $error("Write without a response.");

  rd_answer_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_en |=> s_axi_rvalid)
    else $error("Read without a response.");

  off_quiet_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    !st_r.ctrl[CTRL_ON] |-> (cn_event == '0))
    else $error("Change event while the module is off.");

  idle_quiet_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.ctrl[CTRL_STOP_IN_IDLE] && idle_mode) |-> (cn_event == '0))
    else $error("Change event while stopped in idle.");

endmodule // pfcn_port

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import pfcn_pkg::*;

  logic        aclk;
  logic        aresetn;
  logic [15:0] awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [15:0] araddr;
  logic        arvalid;
  logic        rready;
  logic [15:0] pins;
  logic        idle_mode;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic [15:0] pad_out;
  logic [15:0] pad_oe;
  logic [15:0] pu_bits;
  logic [15:0] pd_bits;
  logic        irq;
  logic [33:0] exp_q[$];
  logic [15:0] offs[6];
  logic [31:0] msk[6];
  logic [31:0] cur[6];
  logic [31:0] d;
  int          n_fail;
  int          total_checks;
  int          cyc;

  pfcn_port #(.ADDR_W(16)) pfcn_port_i (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .s_axi_awaddr              (awaddr),
    .s_axi_awvalid             (awvalid),
    .s_axi_awready             (s_axi_awready),
    .s_axi_wdata               (wdata),
    .s_axi_wstrb               (wstrb),
    .s_axi_wvalid              (wvalid),
    .s_axi_wready              (s_axi_wready),
    .s_axi_bresp               (s_axi_bresp),
    .s_axi_bvalid              (s_axi_bvalid),
    .s_axi_bready              (bready),
    .s_axi_araddr              (araddr),
    .s_axi_arvalid             (arvalid),
    .s_axi_arready             (s_axi_arready),
    .s_axi_rdata               (s_axi_rdata),
    .s_axi_rresp               (s_axi_rresp),
    .s_axi_rvalid              (s_axi_rvalid),
    .s_axi_rready              (rready),
    .pin_level_bits            (pins),
    .idle_mode                 (idle_mode),
    .pad_out                   (pad_out),
    .pad_oe                    (pad_oe),
    .weak_pullup_enable_bits   (pu_bits),
    .weak_pulldown_enable_bits (pd_bits),
    .irq                       (irq)
  );

  always #2.5 aclk = ~aclk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The bench only waits on handshakes; the cycle ceiling below cuts a hang.
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [1:0] rsp);
    exp_q.push_back({rsp, ZERO_W});
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= STRB_ALL;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && s_axi_awready) awvalid <= 1'b0;
      if (wvalid && s_axi_wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] v, input logic [1:0] rsp);
    exp_q.push_back({rsp, v});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rready <= 1'b0;
  endtask

  task automatic settle;
    @(posedge aclk);
    #1;
  endtask

  // Every completed response is matched against the oldest note.
  always @(posedge aclk) begin
    if (s_axi_rvalid && rready) begin
      if (exp_q.size() == 0) check({s_axi_rresp, s_axi_rdata}, 34'h3_ffff_ffff);
      else check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid && bready) begin
      if (exp_q.size() == 0) check({s_axi_bresp, ZERO_W}, 34'h3_ffff_ffff);
      else check({s_axi_bresp, ZERO_W}, exp_q.pop_front());
    end
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    aclk = 1'b0; aresetn = 1'b0; awaddr = 16'h0000; awvalid = 1'b0;
    wdata = ZERO_W; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 16'h0000; arvalid = 1'b0; rready = 1'b0; pins = 16'h0000;
    idle_mode = 1'b0; n_fail = 0; total_checks = 0; cyc = 0;
    offs = '{OFF_DIR, OFF_LAT, OFF_ODC, OFF_PU, OFF_PD, OFF_CNEN};
    msk  = '{PIN_IMPL, PIN_IMPL, PIN_IMPL, PIN_IMPL, PIN_IMPL, CN_IMPL};
    d = $urandom(44);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_DIR, DIR_RST, RESP_OKAY);
    rd(OFF_CTRL, CTRL_RST, RESP_OKAY);
    #1;
    check({18'h0_0000, pad_oe}, 34'h0_0000_0000);
    check({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    $display("test reset done");
    @(posedge aclk);
    // Random words, upper halfword included, must come back trimmed.
    for (int r = 0; r < 6; r++) begin
      cur[r] = $urandom;
      wr(offs[r], cur[r], RESP_OKAY);
      rd(offs[r], cur[r] & msk[r], RESP_OKAY);
    end
    wr(OFF_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_CTRL, CTRL_IMPL, RESP_OKAY);
    wr(OFF_CTRL, ZERO_W, RESP_OKAY);
    $display("test masks done");
    for (int r = 0; r < 6; r++) begin
      for (int s = 1; s < 4; s++) begin
        d = $urandom;
        case (s)
          1: cur[r] = cur[r] & ~d;
          2: cur[r] = cur[r] | d;
          default: cur[r] = cur[r] ^ d;
        endcase
        wr(offs[r] + 16'(4 * s), d, RESP_OKAY);
        rd(offs[r], cur[r] & msk[r], RESP_OKAY);
      end
    end
    #1;
    check({18'h0_0000, pad_oe}, {2'h0, ~cur[0] & ~(cur[2] & cur[1]) & PIN_IMPL});
    check({18'h0_0000, pad_out}, {2'h0, cur[1] & PIN_IMPL});
    check({18'h0_0000, pu_bits}, {2'h0, cur[3] & PIN_IMPL});
    check({18'h0_0000, pd_bits}, {2'h0, cur[4] & PIN_IMPL});
    wr(OFF_LVL + 16'h0008, 32'h0000_2000, RESP_OKAY);
    rd(OFF_LAT, (cur[1] | 32'h0000_2000) & PIN_IMPL, RESP_OKAY);
    $display("test aliases done");
    @(posedge aclk);
    pins <= 16'($urandom);
    repeat (3) @(posedge aclk);
    rd(OFF_LVL, {16'h0000, pins} & PIN_IMPL, RESP_OKAY);
    rd(16'h6600, ZERO_W, RESP_SLVERR);
    wr(16'h6600, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFF_IST + 16'h0004, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test level and unmapped done");
    // Pin 6 toggles together with pin 0 but has no flag to set.
    wr(OFF_CNEN, 32'hFFFF_FFFF, RESP_OKAY);
    wr(OFF_IMSK, 32'h0000_FFFF, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_8000, RESP_OKAY);
    pins <= pins ^ 16'h0041;
    repeat (3) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0001, RESP_OKAY);
    #1;
    check({33'h0_0000_0000, irq}, 34'h0_0000_0001);
    wr(OFF_IMSK, ZERO_W, RESP_OKAY);
    settle();
    check({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    wr(OFF_IMSK, CN_IMPL, RESP_OKAY);
    settle();
    check({33'h0_0000_0000, irq}, 34'h0_0000_0001);
    rd(OFF_IST, 32'h0000_0001, RESP_OKAY);
    rd(OFF_IMSK, CN_IMPL, RESP_OKAY);
    wr(OFF_IST, 32'h0000_0001, RESP_OKAY);
    settle();
    check({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    rd(OFF_LVL, {16'h0000, pins} & PIN_IMPL, RESP_OKAY);
    rd(OFF_STAT, ZERO_W, RESP_OKAY);
    $display("test change flags done");
    wr(OFF_CTRL, 32'h0000_A000, RESP_OKAY);
    idle_mode <= 1'b1;
    pins <= pins ^ 16'h0002;
    repeat (3) @(posedge aclk);
    rd(OFF_STAT, ZERO_W, RESP_OKAY);
    idle_mode <= 1'b0;
    pins <= pins ^ 16'h0004;
    repeat (3) @(posedge aclk);
    rd(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    wr(OFF_CTRL, ZERO_W, RESP_OKAY);
    pins <= pins ^ 16'h0008;
    repeat (3) @(posedge aclk);
    wr(OFF_STAT, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_STAT, 32'h0000_0004, RESP_OKAY);
    $display("test idle and off done");
    repeat (2) @(posedge aclk);
    report_and_stop();
  end
endmodule // tb
